// File: hdl/scd_clock_ctl.sv
// Top of the system clock source and divider block.
// Assumes oscillators deliver one-cycle ticks and settle flags on clk.
//
// Function
// - After reset run from fast_osc_a divided by eight.
// - divider_select divides the source by two to its value, reset 3.
// - source_select picks a, ext, slow, b, a/1.5 or b/1.5, reset 0.
// - divider_ready reads 1 once clock passed the divider, resets 1.
// - Source switches on the fly when enabled (fast ones also settled); divider anytime.
// - fast_osc_a runs when forced, requested or selected.
// - fast_osc_b runs when forced, requested or selected.
// - fast_osc_a_trim sets period, 0x00 fastest, resets to factory value.
// - fast_osc_b_trim bits 6:0 set period, resets to factory value.
// - slow_osc_divider divides slow output by 8, 4, 2, 1; reset 3.
// - slow_osc_enable or a watchdog request turns the slow oscillator on.
// - slow_osc_ready reads 1 when the slow oscillator has stabilised.
// - Slow oscillator usable as clock right after it is enabled.
// - Falling slow output edges capture timer count in capture mode.
// - External clock is resynchronised before reaching peripherals.
// - Suspend halts fast oscillators and gates off the system clock.
`timescale 1ns/10ps
module scd_clock_ctl
  import scd_pkg::*;
#(
  parameter logic [7:0] TRIM_A_RST = TRIM_A_FACTORY,
  parameter logic [6:0] TRIM_B_RST = TRIM_B_FACTORY,
  parameter logic [3:0] SLOW_TRIM_RST = SLOW_TRIM_FACTORY
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Oscillator ticks and settle flags
  input wire logic fast_osc_a_tick,
  input wire logic fast_osc_b_tick,
  input wire logic slow_osc_tick,
  input wire logic ext_clock_pin,
  input wire logic fast_osc_a_settled,
  input wire logic fast_osc_b_settled,
  input wire logic slow_osc_settled,
  // Requests from other blocks
  input wire logic fast_osc_a_req,
  input wire logic fast_osc_b_req,
  input wire logic watchdog_slow_req,
  input wire logic suspend,
  input wire logic capture_mode,
  // Clock outputs
  output logic system_clock_en,
  output logic [2:0] active_source,
  output logic ext_clock_sync,
  output logic slow_osc_div_en,
  output logic slow_capture,
  // Oscillator controls
  output logic fast_osc_a_run,
  output logic fast_osc_b_run,
  output logic slow_osc_run,
  output logic [7:0] fast_osc_a_trim,
  output logic [6:0] fast_osc_b_trim,
  output logic [3:0] slow_osc_trim
);

  // ==========================================================
  // Address decode
  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  // ==========================================================
  // Register state
  logic [2:0] div_sel_r, div_sel_nxt;
  logic [2:0] src_sel_r, src_sel_nxt;
  logic force_a_r, force_a_nxt, force_b_r, force_b_nxt;
  logic slow_en_r, slow_en_nxt;
  logic [1:0] slow_div_r, slow_div_nxt;
  logic [7:0] trim_a_nxt;
  logic [6:0] trim_b_nxt;
  logic [3:0] slow_trim_nxt;
  logic wr_go;
  logic div_ready, div_out, mux_en, mux_restart, slow_tick_div, ext_d_r;
  logic [2:0] cur_src;

  assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];

  always_comb begin
    div_sel_nxt = div_sel_r;
    src_sel_nxt = src_sel_r;
    force_a_nxt = force_a_r;
    force_b_nxt = force_b_r;
    slow_en_nxt = slow_en_r;
    slow_div_nxt = slow_div_r;
    trim_a_nxt = fast_osc_a_trim;
    trim_b_nxt = fast_osc_b_trim;
    slow_trim_nxt = slow_osc_trim;
    if (wr_go) begin
      if (reg_hit(avs_address, IDX_CLK_SEL)) begin
        div_sel_nxt = avs_writedata[CSEL_DIV_LSB +: 3];
        src_sel_nxt = avs_writedata[CSEL_SRC_LSB +: 3];
      end else if (reg_hit(avs_address, IDX_SLOW_CTL)) begin
        slow_en_nxt = avs_writedata[SLOW_EN_BIT];
        slow_trim_nxt = avs_writedata[SLOW_TRIM_LSB +: 4];
        slow_div_nxt = avs_writedata[SLOW_DIV_LSB +: 2];
      end else if (reg_hit(avs_address, IDX_TRIM_A)) begin
        trim_a_nxt = avs_writedata[7:0];
      end else if (reg_hit(avs_address, IDX_TRIM_B)) begin
        trim_b_nxt = avs_writedata[6:0];
      end else if (reg_hit(avs_address, IDX_FORCE)) begin
        force_a_nxt = avs_writedata[FORCE_A_BIT];
        force_b_nxt = avs_writedata[FORCE_B_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_sel_r <= DIV_RST;
      src_sel_r <= SRC_RST;
      force_a_r <= 1'b0;
      force_b_r <= 1'b0;
      slow_en_r <= 1'b0;
      slow_div_r <= SLOW_DIV_RST;
      fast_osc_a_trim <= TRIM_A_RST;
      fast_osc_b_trim <= TRIM_B_RST;
      slow_osc_trim <= SLOW_TRIM_RST;
    end else begin
      div_sel_r <= div_sel_nxt;
      src_sel_r <= src_sel_nxt;
      force_a_r <= force_a_nxt;
      force_b_r <= force_b_nxt;
      slow_en_r <= slow_en_nxt;
      slow_div_r <= slow_div_nxt;
      fast_osc_a_trim <= trim_a_nxt;
      fast_osc_b_trim <= trim_b_nxt;
      slow_osc_trim <= slow_trim_nxt;
    end
  end

  // ==========================================================
  // Bus answer: one wait cycle, then a one-cycle acknowledge
  logic wait_nxt;
  logic [31:0] rdata_nxt;
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    if (reg_hit(avs_address, IDX_CLK_SEL)) begin
      rbyte = {div_ready, div_sel_r, 1'b0, src_sel_r};
    end else if (reg_hit(avs_address, IDX_SLOW_CTL)) begin
      rbyte = {slow_en_r, slow_osc_settled, slow_osc_trim, slow_div_r};
    end else if (reg_hit(avs_address, IDX_TRIM_A)) begin
      rbyte = fast_osc_a_trim;
    end else if (reg_hit(avs_address, IDX_TRIM_B)) begin
      rbyte = {1'b0, fast_osc_b_trim};
    end else if (reg_hit(avs_address, IDX_FORCE)) begin
      rbyte = {force_b_r, 3'h0, force_a_r, 3'h0};
    end
    wait_nxt = 1'b1;
    rdata_nxt = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      wait_nxt = 1'b0;
      rdata_nxt = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= wait_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Oscillator enables
  logic sel_a, sel_b, run_a_nxt, run_b_nxt, run_s_nxt;
  logic [3:0] running;

  always_comb begin
    // Source in use keeps running until the mux has left it
    sel_a = (src_sel_r == SRC_FAST_A) || (src_sel_r == SRC_FAST_A_P15)
            || (cur_src == SRC_FAST_A) || (cur_src == SRC_FAST_A_P15);
    sel_b = (src_sel_r == SRC_FAST_B) || (src_sel_r == SRC_FAST_B_P15)
            || (cur_src == SRC_FAST_B) || (cur_src == SRC_FAST_B_P15);
    // Halted in suspend even when forced
    run_a_nxt = !suspend && (force_a_r || fast_osc_a_req || sel_a);
    run_b_nxt = !suspend && (force_b_r || fast_osc_b_req || sel_b);
    run_s_nxt = slow_en_r || watchdog_slow_req;
    // Ext presence is the software's duty; slow needs no settle wait
    running = {fast_osc_b_run && fast_osc_b_settled, slow_osc_run, 1'b1,
               fast_osc_a_run && fast_osc_a_settled};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fast_osc_a_run <= 1'b1;
      fast_osc_b_run <= 1'b0;
      slow_osc_run <= 1'b0;
    end else begin
      fast_osc_a_run <= run_a_nxt;
      fast_osc_b_run <= run_b_nxt;
      slow_osc_run <= run_s_nxt;
    end
  end

  // ==========================================================
  // System clock path
  scd_src_mux u_mux (
    .clk(clk),
    .srst(srst),
    // Ext level becomes a tick on its synchronised rising edge
    .tick_vec({fast_osc_b_tick, slow_osc_tick, ext_clock_sync && !ext_d_r,
               fast_osc_a_tick}),
    .src_running(running),
    .req_src(src_sel_r),
    .hold(suspend),
    .cur_src(cur_src),
    .src_en(mux_en),
    .restart(mux_restart)
  );

  scd_pow2_div #(.SW(3), .CW(7), .SEL_RST(DIV_RST), .RDY_RST(1'b1)) u_sys_div (
    .clk(clk),
    .srst(srst),
    .in_en(mux_en),
    .restart(mux_restart),
    .sel(div_sel_r),
    .out_en(div_out),
    .ready(div_ready)
  );

  // Slow divider: field 0 divides by 8, field 3 passes every tick
  scd_pow2_div #(.SW(2), .CW(3), .SEL_RST(2'(SLOW_DIV_MAX - SLOW_DIV_RST)), .RDY_RST(1'b1))
  u_slow_div (
    .clk(clk),
    .srst(srst),
    .in_en(slow_osc_tick && slow_osc_run),
    .restart(1'b0),
    .sel(2'(SLOW_DIV_MAX - slow_div_r)),
    .out_en(slow_tick_div),
    .ready()
  );

  // ==========================================================
  // Output stage, external resync and capture
  logic ext_s1_r, ext_s2_r, slow_lvl_r;
  logic sys_nxt, cap_nxt, lvl_nxt;

  always_comb begin
    sys_nxt = div_out && !suspend;
    lvl_nxt = slow_tick_div ? !slow_lvl_r : slow_lvl_r;
    // A tick while high is the falling edge of the divided output
    cap_nxt = capture_mode && slow_tick_div && slow_lvl_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_clock_sync <= 1'b0;
      ext_d_r <= 1'b0;
      slow_lvl_r <= 1'b0;
      slow_capture <= 1'b0;
      slow_osc_div_en <= 1'b0;
      system_clock_en <= 1'b0;
      active_source <= SRC_RST;
    end else begin
      ext_s1_r <= ext_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_clock_sync <= ext_s2_r;
      ext_d_r <= ext_clock_sync;
      slow_lvl_r <= lvl_nxt;
      slow_capture <= cap_nxt;
      slow_osc_div_en <= slow_tick_div;
      system_clock_en <= sys_nxt;
      active_source <= cur_src;
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_RESET_SETUP:
  assert property ($fell(srst) |-> div_sel_r == 3'h3 && src_sel_r == 3'h0 && fast_osc_a_run)
    else $error("reset clock setup wrong");

  AST_DIV_CHANGE:
  assert property (wr_go && reg_hit(avs_address, IDX_CLK_SEL)
                   && avs_writedata[6:4] != div_sel_r |=> ##1 !div_ready)
    else $error("divider ready not cleared on divider change");

  AST_DIV_READY:
  assert property ($rose(div_ready) |-> $past(mux_en))
    else $error("divider ready rose without a source tick");

  AST_EXT_SWITCH:
  assert property (wr_go && reg_hit(avs_address, IDX_CLK_SEL) && avs_writedata[2:0] == 3'h1
                   |-> ##[1:3] cur_src == 3'h1)
    else $error("switch to external clock did not happen");

  AST_FORCE_A:
  assert property (force_a_r && !suspend |=> fast_osc_a_run)
    else $error("forced fast_osc_a not running");

  AST_FORCE_B:
  assert property ((force_b_r || fast_osc_b_req) && !suspend |=> fast_osc_b_run)
    else $error("fast_osc_b not running when forced or requested");

  AST_WDT_SLOW:
  assert property (watchdog_slow_req |=> slow_osc_run)
    else $error("slow oscillator off under watchdog request");

  AST_CAPTURE:
  assert property (slow_capture |-> $past(capture_mode) && $past(slow_tick_div)
                   && !slow_lvl_r)
    else $error("capture without slow falling edge");

  AST_EXT_SYNC:
  assert property (!$past(srst) && !$past(srst, 2) && !$past(srst, 3)
                   |-> ext_clock_sync == $past(ext_clock_pin, 3))
    else $error("external clock not resynchronised");

  AST_SUSPEND:
  assert property (suspend |=> !system_clock_en && !fast_osc_a_run && !fast_osc_b_run)
    else $error("clock or fast oscillator alive in suspend");

endmodule // scd_clock_ctl

// File: hdl/scd_pkg.sv
// Package for the system clock source and divider block.
// Assumes a single 10 MHz clock and registers behind an Avalon-MM slave.
package scd_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CLK_SEL = 8'hA9;
  localparam logic [7:0] IDX_SLOW_CTL = 8'hB1;
  localparam logic [7:0] IDX_TRIM_A = 8'hC7;
  localparam logic [7:0] IDX_TRIM_B = 8'hD6;
  localparam logic [7:0] IDX_FORCE = 8'hEF;

  // ==========================================================
  // Field positions
  localparam int CSEL_RDY_BIT = 7;
  localparam int CSEL_DIV_LSB = 4;
  localparam int CSEL_SRC_LSB = 0;
  localparam int FORCE_B_BIT = 7;
  localparam int FORCE_A_BIT = 3;
  localparam int SLOW_EN_BIT = 7;
  localparam int SLOW_RDY_BIT = 6;
  localparam int SLOW_TRIM_LSB = 2;
  localparam int SLOW_DIV_LSB = 0;

  // ==========================================================
  // Reset values
  localparam logic [2:0] DIV_RST = 3'h3;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [1:0] SLOW_DIV_RST = 2'h3;
  localparam logic [7:0] TRIM_A_FACTORY = 8'h80;
  localparam logic [6:0] TRIM_B_FACTORY = 7'h40;
  localparam logic [3:0] SLOW_TRIM_FACTORY = 4'h8;
  localparam logic [1:0] SLOW_DIV_MAX = 2'h3;

  // ==========================================================
  // Source codes
  localparam logic [2:0] SRC_FAST_A = 3'h0;
  localparam logic [2:0] SRC_EXT = 3'h1;
  localparam logic [2:0] SRC_SLOW = 3'h2;
  localparam logic [2:0] SRC_FAST_B = 3'h3;
  localparam logic [2:0] SRC_FAST_A_P15 = 3'h4;
  localparam logic [2:0] SRC_FAST_B_P15 = 3'h7;
  localparam logic [1:0] PRE_LAST = 2'h2;

  // ==========================================================
  // Source switch states
  typedef enum logic [0:0] {SW_IDLE, SW_WAIT} scd_sw_t;

endpackage

// File: hdl/scd_pow2_div.sv
// Power-of-two tick divider: passes one input tick out of 2^sel.
// Assumes in_en is a one-cycle tick enable on clk.
`timescale 1ns/10ps
module scd_pow2_div
  import scd_pkg::*;
#(
  parameter int SW = 3,
  parameter int CW = 7,
  parameter logic [SW-1:0] SEL_RST = '0,
  parameter logic RDY_RST = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic in_en,
  input wire logic restart,
  input wire logic [SW-1:0] sel,
  // Result
  output logic out_en,
  output logic ready
);

  logic [CW-1:0] cnt_r, cnt_nxt, mask;
  logic [SW-1:0] sel_r, sel_nxt;
  logic out_nxt, rdy_nxt;

  // ==========================================================
  // Counter
  always_comb begin
    mask = ~({CW{1'b1}} << sel);
    cnt_nxt = cnt_r;
    sel_nxt = sel;
    out_nxt = 1'b0;
    rdy_nxt = ready;
    // Restart on any change so the first output period is full length
    if (restart || sel != sel_r) begin
      cnt_nxt = '0;
      rdy_nxt = 1'b0;
    end else if (in_en) begin
      if ((cnt_r & mask) == mask) begin
        cnt_nxt = '0;
        out_nxt = 1'b1;
        rdy_nxt = 1'b1;
      end else begin
        cnt_nxt = CW'(cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      sel_r <= SEL_RST;
      out_en <= 1'b0;
      ready <= RDY_RST;
    end else begin
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
      out_en <= out_nxt;
      ready <= rdy_nxt;
    end
  end

endmodule // scd_pow2_div

// File: hdl/scd_src_mux.sv
// Source multiplexer with 1.5 pre-scale and safe switching.
// Assumes source ticks are one-cycle enables indexed a, ext, slow, b.
`timescale 1ns/10ps
module scd_src_mux
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sources
  input wire logic [3:0] tick_vec,
  input wire logic [3:0] src_running,
  // Control
  input wire logic [2:0] req_src,
  input wire logic hold,
  // Result
  output logic [2:0] cur_src,
  output logic src_en,
  output logic restart
);

  scd_sw_t st_r, st_nxt;
  logic [2:0] cur_nxt;
  logic [1:0] pre_r, pre_nxt;
  logic en_nxt, rst_nxt, req_ok;

  // ==========================================================
  // Switch control and pre-scale
  always_comb begin
    req_ok = (req_src != 3'h5) && (req_src != 3'h6);
    st_nxt = st_r;
    cur_nxt = cur_src;
    pre_nxt = pre_r;
    rst_nxt = 1'b0;
    en_nxt = 1'b0;
    case (st_r)
      SW_IDLE: begin
        if (req_ok && req_src != cur_src) begin
          st_nxt = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (!req_ok || req_src == cur_src) begin
          st_nxt = SW_IDLE;
        end else if (src_running[req_src[1:0]]) begin
          cur_nxt = req_src;
          rst_nxt = 1'b1;
          pre_nxt = '0;
          st_nxt = SW_IDLE;
        end
      end
      default: st_nxt = SW_IDLE;
    endcase
    // Codes 4 and 7 pass two ticks of every three
    if (tick_vec[cur_src[1:0]] && !rst_nxt && !hold) begin
      if (cur_src[2]) begin
        pre_nxt = (pre_r == PRE_LAST) ? 2'h0 : 2'(pre_r + 1'b1);
        en_nxt = (pre_r != PRE_LAST);
      end else begin
        en_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= SW_IDLE;
      cur_src <= SRC_RST;
      pre_r <= '0;
      src_en <= 1'b0;
      restart <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cur_src <= cur_nxt;
      pre_r <= pre_nxt;
      src_en <= en_nxt;
      restart <= rst_nxt;
    end
  end

endmodule // scd_src_mux

// File: verif/scd_clock_ctl_tb.sv
// Self-checking bench for the system clock source and divider block.
// Assumes scd_pkg and scd_clock_ctl are compiled first; the bench is the Avalon master.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module scd_clock_ctl_tb
  import scd_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fast_osc_a_tick = 1'b0;
  logic fast_osc_b_tick = 1'b0;
  logic slow_osc_tick = 1'b0;
  logic ext_clock_pin = 1'b0;
  logic fast_osc_a_settled = 1'b1;
  logic fast_osc_b_settled = 1'b1;
  logic slow_osc_settled = 1'b1;
  logic fast_osc_a_req = 1'b0;
  logic fast_osc_b_req = 1'b0;
  logic watchdog_slow_req = 1'b0;
  logic suspend = 1'b0;
  logic capture_mode = 1'b0;
  logic system_clock_en, ext_clock_sync, slow_osc_div_en, slow_capture;
  logic fast_osc_a_run, fast_osc_b_run, slow_osc_run;
  logic [2:0] active_source;
  logic [7:0] fast_osc_a_trim;
  logic [6:0] fast_osc_b_trim;
  logic [3:0] slow_osc_trim;
  logic [2:0] hist = 3'h0;
  int cnt = 0;
  int err_count = 0;
  int tests_run = 0;

  scd_clock_ctl dut_u (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_osc_a_tick(fast_osc_a_tick), .fast_osc_b_tick(fast_osc_b_tick),
    .slow_osc_tick(slow_osc_tick), .ext_clock_pin(ext_clock_pin),
    .fast_osc_a_settled(fast_osc_a_settled), .fast_osc_b_settled(fast_osc_b_settled),
    .slow_osc_settled(slow_osc_settled), .fast_osc_a_req(fast_osc_a_req),
    .fast_osc_b_req(fast_osc_b_req), .watchdog_slow_req(watchdog_slow_req),
    .suspend(suspend), .capture_mode(capture_mode), .system_clock_en(system_clock_en),
    .active_source(active_source), .ext_clock_sync(ext_clock_sync),
    .slow_osc_div_en(slow_osc_div_en), .slow_capture(slow_capture),
    .fast_osc_a_run(fast_osc_a_run), .fast_osc_b_run(fast_osc_b_run),
    .slow_osc_run(slow_osc_run), .fast_osc_a_trim(fast_osc_a_trim),
    .fast_osc_b_trim(fast_osc_b_trim), .slow_osc_trim(slow_osc_trim)
  );

  // ==========================================================
  // Clock and oscillator ticks
  // Distinct tick periods let the measured period name the source in use, except b and a/1.5, which both measure 6 at divide by two
  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cnt <= cnt + 1;
    fast_osc_a_tick <= (cnt % 2 == 0);
    fast_osc_b_tick <= (cnt % 3 == 0);
    slow_osc_tick <= (cnt % 5 == 0);
    ext_clock_pin <= ((cnt % 8) < 4);
    hist <= {hist[1:0], ext_clock_pin};
  end

  // ==========================================================
  // Bus tasks
  task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] d,
      input logic [3:0] be, output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer({idx, 2'b00}, 1'b1, d, 4'h1, q);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    xfer({idx, 2'b00}, 1'b0, 8'h00, 4'h1, q);
  endtask

  // ==========================================================
  // Pulse measurement: 0 system clock, 1 divided slow, 2 capture
  function automatic logic pick(input int s);
    if (s == 0) return system_clock_en;
    if (s == 1) return slow_osc_div_en;
    return slow_capture;
  endfunction

  task automatic gap(input int s, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(s) !== 1'b1 && n < 3000);
  endtask

  // Skips the first gaps so a restart transient is not measured
  task automatic period(input int s, output int p);
    gap(s, p);
    gap(s, p);
    gap(s, p);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] q;
    int p;
    rd(IDX_CLK_SEL, q);
    `CHK(q, 8'hB0)
    rd(IDX_SLOW_CTL, q);
    `CHK(q, 8'h63)
    rd(IDX_TRIM_A, q);
    `CHK(q, 8'h80)
    rd(IDX_TRIM_B, q);
    `CHK(q, 8'h40)
    rd(IDX_FORCE, q);
    `CHK(q, 8'h00)
    `CHK(active_source, SRC_FAST_A)
    period(0, p);
    `CHK(p, 16)
  endtask

  task automatic t_divider();
    logic [7:0] q;
    int p;
    for (int d = 0; d < 8; d++) begin
      wr(IDX_CLK_SEL, {1'b0, 3'(d), 4'h0});
      period(0, p);
      `CHK(p, 2 << d)
    end
    wr(IDX_CLK_SEL, 8'h00);
    wr(IDX_CLK_SEL, 8'h70);
    repeat (4) @(posedge clk);
    rd(IDX_CLK_SEL, q);
    `CHK(q[7], 1'b0)
    period(0, p);
    rd(IDX_CLK_SEL, q);
    `CHK(q, 8'hF0)
  endtask

  task automatic t_source();
    logic [2:0] code [6] = '{3'h3, 3'h4, 3'h7, 3'h1, 3'h2, 3'h0};
    int per [6] = '{6, 6, 9, 16, 10, 4};
    logic [7:0] q;
    int p;
    wr(IDX_SLOW_CTL, 8'hA3);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CLK_SEL, {5'h02, code[i]});
      wr(IDX_CLK_SEL, {5'h02, code[i]});
      period(0, p);
      `CHK(p, per[i])
      `CHK(active_source, code[i])
      rd(IDX_CLK_SEL, q);
      `CHK(q[2:0], code[i])
      if (code[i] == 3'h3) `CHK(fast_osc_b_run, 1'b1)
    end
    wr(IDX_CLK_SEL, 8'h15);
    repeat (10) @(posedge clk);
    `CHK(active_source, SRC_FAST_A)
    fast_osc_b_settled <= 1'b0;
    wr(IDX_CLK_SEL, 8'h13);
    repeat (30) @(posedge clk);
    `CHK(active_source, SRC_FAST_A)
    fast_osc_b_settled <= 1'b1;
    period(0, p);
    `CHK(p, 6)
    `CHK(active_source, SRC_FAST_B)
    wr(IDX_CLK_SEL, 8'h10);
  endtask

  task automatic t_force();
    logic [7:0] q;
    wr(IDX_CLK_SEL, 8'h11);
    repeat (4) @(posedge clk);
    `CHK({fast_osc_a_run, fast_osc_b_run}, 2'b00)
    wr(IDX_FORCE, 8'h88);
    repeat (4) @(posedge clk);
    `CHK({fast_osc_a_run, fast_osc_b_run}, 2'b11)
    rd(IDX_FORCE, q);
    `CHK(q, 8'h88)
    wr(IDX_FORCE, 8'hFF);
    rd(IDX_FORCE, q);
    `CHK(q, 8'h88)
    wr(IDX_FORCE, 8'h00);
    fast_osc_a_req <= 1'b1;
    fast_osc_b_req <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({fast_osc_a_run, fast_osc_b_run}, 2'b11)
    fast_osc_a_req <= 1'b0;
    fast_osc_b_req <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({fast_osc_a_run, fast_osc_b_run}, 2'b00)
    wr(IDX_CLK_SEL, 8'h10);
  endtask

  task automatic t_regs();
    logic [7:0] q;
    wr(IDX_TRIM_A, 8'hFF);
    `CHK(fast_osc_a_trim, 8'hFF)
    wr(IDX_TRIM_A, 8'h00);
    rd(IDX_TRIM_A, q);
    `CHK(q, 8'h00)
    xfer({IDX_TRIM_A, 2'b00}, 1'b1, 8'h5A, 4'h0, q);
    `CHK(fast_osc_a_trim, 8'h00)
    wr(IDX_TRIM_B, 8'hFF);
    rd(IDX_TRIM_B, q);
    `CHK(q, 8'h7F)
    `CHK(fast_osc_b_trim, 7'h7F)
    wr(8'h10, 8'hFF);
    rd(8'h10, q);
    `CHK(q, 8'h00)
    xfer({IDX_TRIM_B, 2'b01}, 1'b0, 8'h00, 4'h1, q);
    `CHK(q, 8'h00)
  endtask

  task automatic t_slow();
    logic [7:0] q;
    int p;
    wr(IDX_SLOW_CTL, 8'h23);
    wr(IDX_SLOW_CTL, 8'h3C);
    `CHK(slow_osc_trim, 4'hF)
    `CHK(slow_osc_run, 1'b0)
    watchdog_slow_req <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(slow_osc_run, 1'b1)
    watchdog_slow_req <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(IDX_SLOW_CTL, {2'b10, 4'hF, 2'(d)});
      period(1, p);
      `CHK(p, 5 * (8 >> d))
    end
    capture_mode <= 1'b1;
    period(2, p);
    `CHK(p, 10)
    capture_mode <= 1'b0;
    gap(2, p);
    `CHK(p, 3000)
    slow_osc_settled <= 1'b0;
    rd(IDX_SLOW_CTL, q);
    `CHK(q[SLOW_RDY_BIT], 1'b0)
    slow_osc_settled <= 1'b1;
  endtask

  task automatic t_sync();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      `CHK(ext_clock_sync, hist[2])
    end
  endtask

  task automatic t_suspend();
    int p;
    suspend <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({fast_osc_a_run, fast_osc_b_run}, 2'b00)
    gap(0, p);
    `CHK(p, 3000)
    suspend <= 1'b0;
    period(0, p);
    `CHK(p, 4)
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    fork
      begin
        repeat (60000) @(posedge clk);
        err_count++;
        results();
      end
    join_none
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_divider();
    t_source();
    t_force();
    t_regs();
    t_slow();
    t_sync();
    t_suspend();
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    results();
  end
endmodule // scd_clock_ctl_tb
